// file: plic_top.sv
`timescale 1ns/10ps
`include "plic_consts.svh"
module plic_top #(
  parameter logic [4:0] PHY_ADDR = `PLIC_PHY_ADDR_DEF
) (
  input wire logic mclk_i, // 100 MHz system clock
  input wire logic srst_i, // sync reset, active high
  input wire logic mdc_i, // management clock pin
  input wire logic mdio_i, // management data in
  output logic mdio_o, // management data out
  output logic mdio_oe_n_o, // low while driving data
  input wire logic [10:0] evt_cond_i, // event condition levels
  input wire logic rx_err_i, // receive error pulse
  input wire logic rmii_mode_i, // reduced-pin mode active
  input wire logic [6:0] led_status_i, // link, act, tx, rx, col, speed, fdx
  input wire logic link_stat_i, // link status level
  output logic led0_o, // first indicator
  output logic led1_o, // second indicator
  output logic int_o, // interrupt pin level
  output logic int_oe_n_o // low while driving interrupt
);
  plic_reg_if bus ();

  plic_pkg::plic_reg_word_type led_sel_q;
  plic_pkg::plic_reg_word_type rxerr_cnt_q;
  plic_pkg::plic_reg_word_type irq_ctrl_q;
  logic [10:0] flags_q;
  logic [10:0] cond_q;
  logic [10:0] flag_set;
  logic [10:0] irq_en;
  logic wr_led, wr_cnt, wr_ctrl, wr_flag, rd_flag;
  logic irq_oe, irq_rdclr, irq_pol, irq_autoclr, irq_rearm;
  logic irq_active;

  ////////////////////////////////////////////////////////////////////
  // serial management slave
  // one strobe per frame at most, so a read and a write never meet
  plic_mdio #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n_o(mdio_oe_n_o),
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_led = bus.wr && (bus.addr == `PLIC_LED_SEL_ADDR);
  assign wr_cnt = bus.wr && (bus.addr == `PLIC_RXERR_CNT_ADDR);
  assign wr_ctrl = bus.wr && (bus.addr == `PLIC_IRQ_CTRL_ADDR);
  assign wr_flag = bus.wr && (bus.addr == `PLIC_IRQ_FLAG_ADDR);
  assign rd_flag = bus.rd && (bus.addr == `PLIC_IRQ_FLAG_ADDR);

  assign irq_oe = irq_ctrl_q[`PLIC_IRQ_OE_BIT];
  assign irq_rdclr = irq_ctrl_q[`PLIC_IRQ_RDCLR_BIT];
  assign irq_pol = irq_ctrl_q[`PLIC_IRQ_POL_BIT];
  assign irq_autoclr = irq_ctrl_q[`PLIC_IRQ_AUTOCLR_BIT];
  assign irq_rearm = irq_ctrl_q[`PLIC_IRQ_REARM_BIT];
  assign irq_en = irq_ctrl_q[`PLIC_IRQ_SRC_NUM-1:0];

  // the flag word is only eleven bits wide; its upper bits read as zero
  // read mux; unmapped addresses read as zero
  always_comb begin
    unique case (bus.addr)
      `PLIC_LED_SEL_ADDR: bus.rdata = led_sel_q;
      `PLIC_RXERR_CNT_ADDR: bus.rdata = rxerr_cnt_q;
      `PLIC_IRQ_CTRL_ADDR: bus.rdata = irq_ctrl_q;
      `PLIC_IRQ_FLAG_ADDR: bus.rdata = {5'h00, flags_q};
      default: bus.rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // indicator selectors; reserved upper bits are plain storage
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      led_sel_q <= `PLIC_LED_SEL_RST;
    end else if (wr_led) begin
      led_sel_q <= bus.wdata;
    end
  end

  plic_led #(
    .TOP_IS_LINK(1'b1)
  ) u_led0 (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .sel_i(led_sel_q[`PLIC_SEL0_LSB +: `PLIC_SEL_W]),
    .status_i(led_status_i),
    .link_stat_i(link_stat_i),
    .led_o(led0_o)
  );

  plic_led #(
    .TOP_IS_LINK(1'b0)
  ) u_led1 (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .sel_i(led_sel_q[`PLIC_SEL1_LSB +: `PLIC_SEL_W]),
    .status_i(led_status_i),
    .link_stat_i(link_stat_i),
    .led_o(led1_o)
  );

  ////////////////////////////////////////////////////////////////////
  // receive error count
  // a write in the same cycle as an error wins; the count wraps, it does not saturate
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rxerr_cnt_q <= `PLIC_RXERR_CNT_RST;
    end else if (wr_cnt) begin
      rxerr_cnt_q <= bus.wdata;
    end else if (rx_err_i && rmii_mode_i) begin
      rxerr_cnt_q <= rxerr_cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt control
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_ctrl_q <= `PLIC_IRQ_CTRL_RST;
    end else if (wr_ctrl) begin
      irq_ctrl_q <= bus.wdata;
    end
  end

  // previous condition level, for rising-edge capture
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cond_q <= 11'h000;
    end else begin
      cond_q <= evt_cond_i;
    end
  end

  // flags record the arrival of a condition, so a cleared flag stays
  // cleared while the condition lingers
  assign flag_set = evt_cond_i & ~cond_q;

  ////////////////////////////////////////////////////////////////////
  // event flags
  // every clear path is overridden by a new arrival in the same cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flags_q <= `PLIC_IRQ_FLAG_RST;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr(flags_q, evt_cond_i, bus.wdata[10:0]));
    end
  end

  // combined clear mask for the three clear policies
  function automatic logic [10:0] flag_clr(input logic [10:0] flg, input logic [10:0] cnd,
                                           input logic [10:0] wd);
    logic [10:0] m;
    m = 11'h000;
    if (rd_flag && irq_rdclr) m = m | flg;
    if (irq_autoclr) m = m | ~cnd;
    if (wr_flag) m = m | (irq_rearm ? (wd & ~cnd) : wd);
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // enabled flag drives pin
  assign irq_active = |(flags_q & irq_en);

  // registered so the pin never glitches while flags and enables settle
  // pin register; inactive level is held even when released
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      int_o <= 1'b1;
      int_oe_n_o <= 1'b1;
    end else begin
      int_oe_n_o <= ~irq_oe;
      int_o <= (irq_active && irq_oe) ? irq_pol : ~irq_pol;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  // each guarded output is registered, so the checks look one cycle on
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  chk_int_gate_off: assert property (
    !irq_oe |=> int_oe_n_o && (int_o == !$past(irq_pol)))
    else $error("interrupt pin driven while output disabled");

  chk_int_active_level: assert property (
    (irq_oe && irq_active) |=> !int_oe_n_o && (int_o == $past(irq_pol)))
    else $error("interrupt pin at wrong active level");

  chk_enable_masks_pin: assert property (
    ((flags_q & irq_en) == 11'h000) |=> (int_o == !$past(irq_pol)))
    else $error("disabled source raised interrupt");

  chk_read_clears: assert property (
    (rd_flag && irq_rdclr && (flag_set == 11'h000)) |=> (flags_q == 11'h000))
    else $error("flag survived clearing read");

  chk_read_keeps: assert property (
    (rd_flag && !irq_rdclr && !irq_autoclr) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("read changed flags with clear disabled");

  chk_auto_clear: assert property (
    (irq_autoclr && !wr_ctrl) |=> ((flags_q & ~$past(evt_cond_i)) == 11'h000))
    else $error("flag kept after condition removed");

  chk_flag_sticky: assert property (
    (!irq_autoclr && !wr_flag && !rd_flag) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag dropped without a clear");

  chk_w1c_plain: assert property (
    (wr_flag && !irq_rearm && (flag_set == 11'h000))
      |=> ((flags_q & $past(bus.wdata[10:0])) == 11'h000))
    else $error("write one failed to clear flag");

  chk_w1c_rearm: assert property (
    (wr_flag && irq_rearm && !irq_autoclr)
      |=> ((flags_q & $past(bus.wdata[10:0] & evt_cond_i & flags_q))
           == $past(bus.wdata[10:0] & evt_cond_i & flags_q)))
    else $error("rearm write cleared a live flag");

  chk_flag_capture: assert property (
    (flag_set != 11'h000) |=> ((flags_q & $past(flag_set)) == $past(flag_set)))
    else $error("event arrival not recorded");

  chk_led_dark: assert property (
    (led_sel_q[5:3] == `PLIC_LED_ALT) |=> !led1_o)
    else $error("second indicator lit on off code");

  chk_led_link_code: assert property (
    (led_sel_q[2:0] == `PLIC_LED_ALT) |=> (led0_o == $past(link_stat_i)))
    else $error("first indicator not following link status");

  chk_led_code_map: assert property (
    (led_sel_q[2:0] != `PLIC_LED_ALT) |=> (led0_o == $past(led_status_i[led_sel_q[2:0]])))
    else $error("first indicator code map wrong");

  chk_rxerr_count: assert property (
    (rx_err_i && rmii_mode_i && !wr_cnt) |=> (rxerr_cnt_q == $past(rxerr_cnt_q) + 16'h0001))
    else $error("receive error not counted");

  chk_rxerr_write: assert property (
    wr_cnt |=> (rxerr_cnt_q == $past(bus.wdata)))
    else $error("receive error count write lost");

  // register writes land whole, reserved selector bits included
  chk_led_sel_write: assert property (
    wr_led |=> (led_sel_q == $past(bus.wdata)))
    else $error("indicator select write lost");

  chk_led1_code_map: assert property (
    (led_sel_q[5:3] != `PLIC_LED_ALT) |=> (led1_o == $past(led_status_i[led_sel_q[5:3]])))
    else $error("second indicator code map wrong");

  // outside reduced-pin mode the count must not drift
  chk_rxerr_idle: assert property (
    (!rmii_mode_i && !wr_cnt) |=> (rxerr_cnt_q == $past(rxerr_cnt_q)))
    else $error("receive error count moved outside reduced-pin mode");

  chk_ctrl_write: assert property (
    wr_ctrl |=> (irq_ctrl_q == $past(bus.wdata)))
    else $error("interrupt control write lost");

  // an enabled output must really take the pin
  chk_oe_follows: assert property (
    irq_oe |=> !int_oe_n_o)
    else $error("interrupt pin released while output enabled");

  cov_irq_raised: cover property (irq_oe && irq_active ##1 !int_oe_n_o);
  cov_read_clear: cover property (rd_flag && irq_rdclr && (flags_q != 11'h000));
  cov_rearm_write: cover property (wr_flag && irq_rearm && ((evt_cond_i & flags_q) != 11'h000));
  cov_auto_clear: cover property (irq_autoclr && (flags_q != 11'h000) ##1 (flags_q == 11'h000));
  cov_led_off: cover property ((led_sel_q[5:3] == `PLIC_LED_ALT) && led_status_i[5]);

endmodule // plic_top

// file: plic_consts.svh
`ifndef PLIC_CONSTS_SVH
`define PLIC_CONSTS_SVH

// management register addresses
`define PLIC_LED_SEL_ADDR 5'h14
`define PLIC_RXERR_CNT_ADDR 5'h15
`define PLIC_IRQ_CTRL_ADDR 5'h16
`define PLIC_IRQ_FLAG_ADDR 5'h17

// reset values
`define PLIC_LED_SEL_RST 16'h3fe9
`define PLIC_RXERR_CNT_RST 16'h0000
`define PLIC_IRQ_CTRL_RST 16'h0000
`define PLIC_IRQ_FLAG_RST 11'h000

// interrupt control field positions
`define PLIC_IRQ_OE_BIT 15
`define PLIC_IRQ_RDCLR_BIT 14
`define PLIC_IRQ_POL_BIT 13
`define PLIC_IRQ_AUTOCLR_BIT 12
`define PLIC_IRQ_REARM_BIT 11
`define PLIC_IRQ_SRC_NUM 11

// indicator selector fields and codes
`define PLIC_SEL0_LSB 0
`define PLIC_SEL1_LSB 3
`define PLIC_SEL_W 3
`define PLIC_LED_LINK 3'h0
`define PLIC_LED_ACT 3'h1
`define PLIC_LED_TXD 3'h2
`define PLIC_LED_RXD 3'h3
`define PLIC_LED_COL 3'h4
`define PLIC_LED_SPEED 3'h5
`define PLIC_LED_FDX 3'h6
`define PLIC_LED_ALT 3'h7

// serial management framing
`define PLIC_MDIO_PRE_BITS 6'h20
`define PLIC_MDIO_HDR_LAST 6'h0c
`define PLIC_MDIO_DATA_LAST 6'h0f
`define PLIC_MDIO_OP_READ 2'h2
`define PLIC_MDIO_OP_WRITE 2'h1
`define PLIC_PHY_ADDR_DEF 5'h01

`endif

// file: plic_pkg.sv
package plic_pkg;

  // serial management frame walker
  typedef enum logic [2:0] {
    MDIO_PREAMBLE,
    MDIO_HEADER,
    MDIO_TURN,
    MDIO_WDATA,
    MDIO_RDATA
  } plic_mdio_state_type;

  typedef logic [15:0] plic_reg_word_type;

endpackage

// file: plic_reg_if.sv
`timescale 1ns/10ps
interface plic_reg_if;
  logic [4:0] addr;
  plic_pkg::plic_reg_word_type wdata;
  plic_pkg::plic_reg_word_type rdata;
  logic wr;
  logic rd;

  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// file: plic_mdio.sv
`timescale 1ns/10ps
`include "plic_consts.svh"
module plic_mdio #(
  parameter logic [4:0] PHY_ADDR = `PLIC_PHY_ADDR_DEF
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic mdc_i, // management clock pin
  input wire logic mdio_i, // management data pin in
  output logic mdio_o, // management data pin out
  output logic mdio_oe_n_o, // low while driving
  plic_reg_if.master bus // register access
);
  logic [2:0] mdc_s_q;
  logic [1:0] dio_s_q;
  plic_pkg::plic_mdio_state_type st_q;
  logic [5:0] cnt_q;
  logic [15:0] sh_q;
  logic is_rd_q;
  logic [4:0] addr_q;
  logic mdc_rise, bit_in, hdr_done, hdr_ok;
  logic [12:0] hdr;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; data takes the second stage, the clock edge detect compares the second and third
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mdc_s_q <= 3'h0;
      dio_s_q <= 2'h3;
    end else begin
      mdc_s_q <= {mdc_s_q[1:0], mdc_i};
      dio_s_q <= {dio_s_q[0], mdio_i};
    end
  end

  assign mdc_rise = mdc_s_q[1] & ~mdc_s_q[2];
  assign bit_in = dio_s_q[1];
  assign hdr = {sh_q[11:0], bit_in};
  assign hdr_done = mdc_rise && (st_q == plic_pkg::MDIO_HEADER) && (cnt_q == `PLIC_MDIO_HDR_LAST);
  assign hdr_ok = hdr[12] && (hdr[9:5] == PHY_ADDR);

  // strobes are single system cycles; read data is captured in the same cycle
  assign bus.rd = hdr_done && hdr_ok && (hdr[11:10] == `PLIC_MDIO_OP_READ);
  assign bus.wr = mdc_rise && (st_q == plic_pkg::MDIO_WDATA) && (cnt_q == `PLIC_MDIO_DATA_LAST);
  assign bus.addr = (st_q == plic_pkg::MDIO_HEADER) ? hdr[4:0] : addr_q;
  assign bus.wdata = {sh_q[14:0], bit_in};

  ////////////////////////////////////////////////////////////////////
  // frame walker, advanced on each rising management clock
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q <= plic_pkg::MDIO_PREAMBLE;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      is_rd_q <= 1'b0;
      addr_q <= 5'h00;
      mdio_o <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else if (mdc_rise) begin
      unique case (st_q)
        plic_pkg::MDIO_PREAMBLE: begin
          if (bit_in) begin
            if (cnt_q != `PLIC_MDIO_PRE_BITS) cnt_q <= cnt_q + 6'h01;
          end else if (cnt_q == `PLIC_MDIO_PRE_BITS) begin
            st_q <= plic_pkg::MDIO_HEADER;
            cnt_q <= 6'h00;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        plic_pkg::MDIO_HEADER: begin
          sh_q <= {sh_q[14:0], bit_in};
          cnt_q <= cnt_q + 6'h01;
          if (hdr_done) begin
            cnt_q <= 6'h00;
            addr_q <= hdr[4:0];
            is_rd_q <= bus.rd;
            sh_q <= bus.rdata;
            // other addresses and bad opcodes wait for the next preamble
            if (bus.rd || (hdr_ok && hdr[11:10] == `PLIC_MDIO_OP_WRITE)) begin
              st_q <= plic_pkg::MDIO_TURN;
            end else begin
              st_q <= plic_pkg::MDIO_PREAMBLE;
            end
          end
        end
        plic_pkg::MDIO_TURN: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            // first turnaround bit: on a read take the line, drive zero
            mdio_o <= 1'b0;
            mdio_oe_n_o <= ~is_rd_q;
          end else begin
            cnt_q <= 6'h00;
            st_q <= is_rd_q ? plic_pkg::MDIO_RDATA : plic_pkg::MDIO_WDATA;
            mdio_o <= is_rd_q ? sh_q[15] : 1'b1;
            if (is_rd_q) sh_q <= {sh_q[14:0], 1'b0};
          end
        end
        plic_pkg::MDIO_WDATA: begin
          sh_q <= {sh_q[14:0], bit_in};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == `PLIC_MDIO_DATA_LAST) begin
            st_q <= plic_pkg::MDIO_PREAMBLE;
            cnt_q <= 6'h00;
          end
        end
        plic_pkg::MDIO_RDATA: begin
          cnt_q <= cnt_q + 6'h01;
          mdio_o <= sh_q[15];
          sh_q <= {sh_q[14:0], 1'b0};
          if (cnt_q == `PLIC_MDIO_DATA_LAST) begin
            st_q <= plic_pkg::MDIO_PREAMBLE;
            cnt_q <= 6'h00;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
          end
        end
        default: st_q <= plic_pkg::MDIO_PREAMBLE;
      endcase
    end
  end
endmodule // plic_mdio

// file: plic_led.sv
`timescale 1ns/10ps
`include "plic_consts.svh"
module plic_led #(
  parameter bit TOP_IS_LINK = 1'b0
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic [2:0] sel_i, // indicator code
  input wire logic [6:0] status_i, // link, act, tx, rx, col, speed, fdx
  input wire logic link_stat_i, // link status for the top code
  output logic led_o // indicator, high = lit
);
  ////////////////////////////////////////////////////////////////////
  // shared code map
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      led_o <= 1'b0;
    end else if (sel_i == `PLIC_LED_ALT) begin
      led_o <= TOP_IS_LINK ? link_stat_i : 1'b0;
    end else begin
      led_o <= status_i[sel_i];
    end
  end
endmodule // plic_led

// file: plic_sta_model.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// station management model: bus master on the serial management pins
module plic_sta_model (
  output logic mdc_o, // management clock, low outside frames
  output logic mdio_o, // data driven by this model
  output logic mdio_en_o, // high while this model drives the line
  input wire logic mdio_i // resolved line level
);
  // idle: clock parked low, line released to the pull-up
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_en_o = 1'b0;
  end
  // one bit: data moves after the fall, so it is stable across the rise
  task automatic bit_t(input logic b, output logic s);
    begin
      mdio_o = b;
      #62.5;
      s = mdio_i;
      mdc_o = 1'b1;
      #62.5;
      mdc_o = 1'b0;
    end
  endtask
  // every frame carries its own full preamble, the device drops headers without one
  task automatic head(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra);
    logic [13:0] h;
    logic s;
    begin
      h = {2'b01, op, pa, ra};
      mdio_en_o = 1'b1;
      repeat (32) bit_t(1'b1, s);
      for (int i = 13; i >= 0; i--) bit_t(h[i], s);
    end
  endtask
  // write: turnaround 10, then sixteen data bits msb first
  task automatic mgmt_wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    logic s;
    begin
      head(2'h1, pa, ra);
      bit_t(1'b1, s);
      bit_t(1'b0, s);
      for (int i = 15; i >= 0; i--) bit_t(d[i], s);
      mdio_en_o = 1'b0;
    end
  endtask
  // read: release for the turnaround, then sample sixteen bits
  task automatic mgmt_rd(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d);
    logic s;
    begin
      head(2'h2, pa, ra);
      mdio_en_o = 1'b0;
      repeat (2) bit_t(1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        bit_t(1'b1, s);
        d[i] = s;
      end
    end
  endtask
endmodule // plic_sta_model

// file: tb.sv
`timescale 1ns/10ps
`include "plic_consts.svh"
module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic mdc, sta_d, sta_en, mdio_line, dut_mdio, dut_oe_n;
  logic [10:0] evt_cond = 11'h000;
  logic rx_err = 1'b0;
  logic rmii = 1'b0;
  logic link_stat = 1'b0;
  logic [6:0] led_status = 7'h00;
  logic led0, led1, int_pin, int_oe_n;
  int err_count = 0;
  int total_checks = 0;
  integer seed = 32'h60df;
  logic [15:0] m_led = `PLIC_LED_SEL_RST;
  logic [15:0] m_cnt = 16'h0000;
  logic [15:0] m_ctrl = 16'h0000;
  logic [10:0] m_flag = 11'h000;

  // clock and wire resolution, the line has a pull-up when nobody drives
  always #5 mclk = ~mclk;
  assign mdio_line = !dut_oe_n ? dut_mdio : (sta_en ? sta_d : 1'b1);

  plic_top #(.PHY_ADDR(`PLIC_PHY_ADDR_DEF)) u_plic_top (.mclk_i(mclk), .srst_i(srst),
    .mdc_i(mdc), .mdio_i(mdio_line), .mdio_o(dut_mdio), .mdio_oe_n_o(dut_oe_n),
    .evt_cond_i(evt_cond), .rx_err_i(rx_err), .rmii_mode_i(rmii),
    .led_status_i(led_status), .link_stat_i(link_stat), .led0_o(led0), .led1_o(led1),
    .int_o(int_pin), .int_oe_n_o(int_oe_n));
  plic_sta_model u_plic_sta_model (.mdc_o(mdc), .mdio_o(sta_d), .mdio_en_o(sta_en),
    .mdio_i(mdio_line));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      total_checks++;
      if (seen !== exp) begin
        err_count++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic print_verdict;
    begin
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // settle lands on a fixed offset after the edge so drivers never race it
  task automatic settle;
    begin
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask
  function automatic logic [15:0] mv(input logic [4:0] a);
    case (a)
      `PLIC_LED_SEL_ADDR: mv = m_led;
      `PLIC_RXERR_CNT_ADDR: mv = m_cnt;
      `PLIC_IRQ_CTRL_ADDR: mv = m_ctrl;
      `PLIC_IRQ_FLAG_ADDR: mv = {5'h00, m_flag};
      default: mv = 16'h0000;
    endcase
  endfunction
  // register write with the model kept in step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    begin
      u_plic_sta_model.mgmt_wr(`PLIC_PHY_ADDR_DEF, a, d);
      if (a == `PLIC_LED_SEL_ADDR) m_led = d;
      if (a == `PLIC_RXERR_CNT_ADDR) m_cnt = d;
      if (a == `PLIC_IRQ_CTRL_ADDR) m_ctrl = d;
      if (a == `PLIC_IRQ_FLAG_ADDR) m_flag &= ~(d[10:0] & (m_ctrl[11] ? ~evt_cond : 11'h7ff));
      if (m_ctrl[12]) m_flag &= evt_cond;
      settle;
    end
  endtask
  // register read compared with the model; read-clear drops what was read
  task automatic rd(input logic [4:0] a);
    logic [15:0] d;
    logic [15:0] e;
    begin
      e = mv(a);
      u_plic_sta_model.mgmt_rd(`PLIC_PHY_ADDR_DEF, a, d);
      chk(d, e);
      if (a == `PLIC_IRQ_FLAG_ADDR && m_ctrl[14]) m_flag &= ~e[10:0];
      settle;
    end
  endtask
  // event conditions: a flag is raised by the rising condition
  task automatic set_cond(input logic [10:0] c);
    begin
      m_flag |= c & ~evt_cond;
      evt_cond = c;
      if (m_ctrl[12]) m_flag &= c;
      settle;
    end
  endtask
  task automatic pin_chk;
    logic e;
    begin
      e = (m_ctrl[15] && |(m_flag & m_ctrl[10:0])) ? m_ctrl[13] : ~m_ctrl[13];
      chk({15'h0, int_pin}, {15'h0, e});
      chk({15'h0, int_oe_n}, {15'h0, ~m_ctrl[15]});
    end
  endtask
  task automatic led_chk;
    logic [2:0] s0, s1;
    begin
      s0 = m_led[2:0];
      s1 = m_led[5:3];
      chk({15'h0, led0}, {15'h0, (s0 == 3'h7) ? link_stat : led_status[s0]});
      chk({15'h0, led1}, {15'h0, (s1 == 3'h7) ? 1'b0 : led_status[s1]});
    end
  endtask
  task automatic pulse(input int n);
    begin
      rx_err = 1'b1;
      repeat (n) @(posedge mclk);
      #1;
      rx_err = 1'b0;
      if (rmii) m_cnt = m_cnt + n[15:0];
      settle;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge mclk);
    err_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    int j;
    logic [15:0] r;
    repeat (6) @(posedge mclk);
    #1;
    srst = 1'b0;
    settle;
    for (int a = 20; a < 24; a++) rd(a[4:0]);
    pin_chk;
    led_chk;
    // every indicator code, the two selectors set apart to catch a swap
    for (int c = 0; c < 8; c++) begin
      r = $random(seed);
      wr(`PLIC_LED_SEL_ADDR, {r[15:6], ~c[2:0], c[2:0]});
      repeat (2) begin
        r = $random(seed);
        led_status = r[6:0];
        link_stat = r[7];
        settle;
        led_chk;
      end
    end
    rd(`PLIC_LED_SEL_ADDR);
    // receive error count: read/write, wrap, counting only in reduced-pin mode
    r = $random(seed);
    wr(`PLIC_RXERR_CNT_ADDR, r);
    rd(`PLIC_RXERR_CNT_ADDR);
    wr(`PLIC_RXERR_CNT_ADDR, 16'hfffe);
    rmii = 1'b1;
    pulse(3);
    rmii = 1'b0;
    pulse(2);
    rd(`PLIC_RXERR_CNT_ADDR);
    // refusals: foreign station address and unmapped register
    u_plic_sta_model.mgmt_wr(5'h02, `PLIC_RXERR_CNT_ADDR, 16'h1234);
    settle;
    rd(`PLIC_RXERR_CNT_ADDR);
    wr(5'h10, 16'hffff);
    rd(5'h10);
    // each source alone, a disabled neighbour beside it, both polarities
    for (int k = 0; k < 11; k++) begin
      j = (k + 1) % 11;
      wr(`PLIC_IRQ_CTRL_ADDR, 16'h8000 | (k[0] ? 16'h2000 : 16'h0000) | (16'h1 << k));
      set_cond(11'h1 << j);
      pin_chk;
      set_cond((11'h1 << j) | (11'h1 << k));
      pin_chk;
      if (k > 7) rd(`PLIC_IRQ_FLAG_ADDR);
      wr(`PLIC_IRQ_FLAG_ADDR, 16'h07ff);
      pin_chk;
      set_cond(11'h000);
    end
    // output disabled, then enabled with a flag pending
    wr(`PLIC_IRQ_CTRL_ADDR, 16'h27ff);
    set_cond(11'h001);
    pin_chk;
    wr(`PLIC_IRQ_CTRL_ADDR, 16'ha7ff);
    pin_chk;
    wr(`PLIC_IRQ_FLAG_ADDR, 16'h07ff);
    // clear on read against plain read
    wr(`PLIC_IRQ_CTRL_ADDR, 16'hc7ff);
    set_cond(11'h004);
    rd(`PLIC_IRQ_FLAG_ADDR);
    rd(`PLIC_IRQ_FLAG_ADDR);
    wr(`PLIC_IRQ_CTRL_ADDR, 16'h87ff);
    set_cond(11'h000);
    set_cond(11'h004);
    rd(`PLIC_IRQ_FLAG_ADDR);
    rd(`PLIC_IRQ_FLAG_ADDR);
    wr(`PLIC_IRQ_FLAG_ADDR, 16'h07ff);
    // auto clear on and off
    wr(`PLIC_IRQ_CTRL_ADDR, 16'h97ff);
    set_cond(11'h010);
    set_cond(11'h000);
    rd(`PLIC_IRQ_FLAG_ADDR);
    wr(`PLIC_IRQ_CTRL_ADDR, 16'h87ff);
    set_cond(11'h010);
    set_cond(11'h000);
    rd(`PLIC_IRQ_FLAG_ADDR);
    // re-arm: write one with the condition present and then absent
    wr(`PLIC_IRQ_CTRL_ADDR, 16'h8fff);
    set_cond(11'h040);
    wr(`PLIC_IRQ_FLAG_ADDR, 16'h0040);
    rd(`PLIC_IRQ_FLAG_ADDR);
    pin_chk;
    set_cond(11'h000);
    wr(`PLIC_IRQ_FLAG_ADDR, 16'h0040);
    rd(`PLIC_IRQ_FLAG_ADDR);
    print_verdict;
  end
endmodule // tb
